// *** core/crypto_channel_eu_scheduler.sv ***
`timescale 1ns/10ps
module crypto_channel_eu_scheduler (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host control, per channel and per unit, with one shared link_data
  input wire logic [sched_pkg::NCH-1:0] link_wr,
  input wire logic [sched_pkg::AW-1:0] link_data,
  input wire logic [sched_pkg::NCH-1:0] chain_done_mode,
  input wire logic [sched_pkg::NCH-1:0] writeback_mode,
  input wire logic [2*sched_pkg::NCH-1:0] prio_cfg,
  input wire logic [sched_pkg::NEU-1:0] static_en,
  input wire logic [2*sched_pkg::NEU-1:0] static_ch,
  input wire logic [sched_pkg::NEU-1:0] static_reset_cmd,
  input wire logic [sched_pkg::NEU*sched_pkg::SVC_W-1:0] eu_service,
  // Descriptor bus, single master
  input wire logic bus_ack,
  input wire logic [sched_pkg::AW-1:0] bus_rdata,
  output logic bus_valid,
  output sched_pkg::bus_req_s bus_req,
  output logic [sched_pkg::AW-1:0] bus_wdata,
  // Execution unit side
  input wire logic [sched_pkg::NEU-1:0] eu_done,
  output logic [sched_pkg::NEU-1:0] eu_mode_set,
  output logic [sched_pkg::NEU-1:0] eu_reset,
  // Status
  output logic [sched_pkg::NCH-1:0] ch_busy,
  output logic [sched_pkg::NCH-1:0] ch_done,
  output logic [sched_pkg::NCH-1:0] ch_irq,
  output logic [sched_pkg::NCH-1:0] illegal_access,
  output logic [sched_pkg::NCH*sched_pkg::AW-1:0] last_unfilled
);
  import sched_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  ch_state_e st_r [NCH];
  ch_state_e st_nxt [NCH];
  logic [AW-1:0] link_r [NCH];
  logic [AW-1:0] link_nxt [NCH];
  logic [AW-1:0] hdr_r [NCH];
  logic [AW-1:0] hdr_nxt [NCH];
  logic [4:0] idx_r [NCH];
  logic [4:0] idx_nxt [NCH];
  logic [1:0] eu_r [NCH];
  logic [1:0] eu_nxt [NCH];
  logic svc_sel_r [NCH];
  logic svc_sel_nxt [NCH];
  logic dyn_r [NCH];
  logic dyn_nxt [NCH];
  logic [NEU-1:0] eu_owned_r, eu_owned_nxt;
  logic [1:0] rr_r [NEU];
  logic [1:0] rr_nxt [NEU];
  logic [1:0] bus_rr_r, bus_rr_nxt;
  logic [NCH-1:0] ill_r, ill_nxt, done_r, done_nxt, irq_r, irq_nxt;
  logic [AW-1:0] unf_r [NCH];
  logic [AW-1:0] unf_nxt [NCH];
  logic bus_valid_r, bus_valid_nxt;
  bus_req_s bus_req_r, bus_req_nxt;
  logic [AW-1:0] bus_wdata_r, bus_wdata_nxt;
  logic [1:0] bus_own_r, bus_own_nxt;
  logic [NEU-1:0] mode_r, mode_nxt, ersr_r, ersr_nxt;
  logic [NPAIR-1:0] skip_r [NCH];
  logic [NPAIR-1:0] skip_nxt [NCH];
  logic [AW-1:0] base_r [NCH];
  logic [AW-1:0] base_nxt [NCH];
  logic [AW-1:0] ptr_r [NCH][NPAIR];
  logic [AW-1:0] ptr_nxt [NCH][NPAIR];
  logic [NCH-1:0] busy_r, busy_nxt;

  // Current service code of a channel
  function automatic logic [SVC_W-1:0] svc_of(input logic [AW-1:0] h,
                                               input logic s);
    svc_of = s ? h[SVC1_LSB +: SVC_W] : h[SVC0_LSB +: SVC_W];
  endfunction : svc_of

  // Channel that wants bus access this cycle
  function automatic logic wants_bus(input ch_state_e s);
    wants_bus = (s == ST_FETCH) || (s == ST_XFER) || (s == ST_UNLOAD) ||
                (s == ST_NOTE);
  endfunction : wants_bus

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [1:0] c;
    logic [1:0] k;
    logic [NCH-1:0] req;
    logic granted;
    logic sta_hit;
    logic [NEU-1:0] free;
    logic fit_free;
    c = 2'h0;
    k = 2'h0;
    req = '0;
    granted = 1'b0;
    sta_hit = 1'b0;
    free = '0;
    fit_free = 1'b0;
    eu_owned_nxt = eu_owned_r;
    bus_rr_nxt = bus_rr_r;
    ill_nxt = ill_r;
    done_nxt = '0;
    irq_nxt = '0;
    bus_valid_nxt = bus_valid_r;
    bus_req_nxt = bus_req_r;
    bus_wdata_nxt = bus_wdata_r;
    bus_own_nxt = bus_own_r;
    mode_nxt = '0;
    ersr_nxt = static_reset_cmd;
    for (int i = 0; i < NCH; i++) begin
      st_nxt[i] = st_r[i];
      link_nxt[i] = link_r[i];
      hdr_nxt[i] = hdr_r[i];
      idx_nxt[i] = idx_r[i];
      eu_nxt[i] = eu_r[i];
      svc_sel_nxt[i] = svc_sel_r[i];
      dyn_nxt[i] = dyn_r[i];
      unf_nxt[i] = unf_r[i];
      skip_nxt[i] = skip_r[i];
      base_nxt[i] = base_r[i];
      ptr_nxt[i] = ptr_r[i];
    end
    for (int e = 0; e < NEU; e++) begin
      rr_nxt[e] = rr_r[e];
    end
    // Bus completion returns to the owning channel
    if (bus_valid_r && bus_ack) begin
      bus_valid_nxt = 1'b0;
      c = bus_own_r;
      case (st_r[c])
        ST_FETCH: begin
          // Word 0 header, then length/pointer pairs, then link
          if (idx_r[c] == 5'h00) begin
            hdr_nxt[c] = bus_rdata;
          end else if (idx_r[c] == 5'(2 * NPAIR + 1)) begin
            link_nxt[c] = bus_rdata;
            base_nxt[c] = link_r[c];
          end else if (idx_r[c][0]) begin
            skip_nxt[c][idx_r[c][3:1]] = bus_rdata == NULL_ADDR;
          end else begin
            ptr_nxt[c][idx_r[c][3:1] - 3'h1] = bus_rdata;
          end
          idx_nxt[c] = idx_r[c] + 5'h01;
          if (idx_r[c] == 5'(2 * NPAIR + 1)) begin
            st_nxt[c] = ST_REQ;
            idx_nxt[c] = 5'h00;
            svc_sel_nxt[c] = 1'b0;
          end
        end
        ST_XFER: begin
          idx_nxt[c] = idx_r[c] + 5'h01;
          if (idx_r[c] == 5'(NPAIR - 1)) begin
            st_nxt[c] = ST_WAIT;
          end
        end
        ST_UNLOAD: st_nxt[c] = ST_RESET;
        ST_NOTE: begin
          st_nxt[c] = link_r[c] != NULL_ADDR ? ST_FETCH : ST_IDLE;
          idx_nxt[c] = 5'h00;
        end
        default: st_nxt[c] = st_r[c];
      endcase
    end else if (bus_valid_r) begin
      unf_nxt[bus_own_r] = bus_req_r.addr;
    end
    // Channel sequencing
    for (int i = 0; i < NCH; i++) begin
      case (st_r[i])
        ST_IDLE: begin
          if (link_wr[i] && link_data != NULL_ADDR) begin
            link_nxt[i] = link_data;
            st_nxt[i] = ST_FETCH;
            idx_nxt[i] = 5'h00;
          end
        end
        ST_MODE: begin
          mode_nxt[eu_r[i]] = 1'b1;
          st_nxt[i] = ST_XFER;
          idx_nxt[i] = 5'h00;
        end
        ST_WAIT: begin
          if (eu_done[eu_r[i]]) begin
            st_nxt[i] = ST_UNLOAD;
          end
        end
        ST_RESET: begin
          if (!svc_sel_r[i] &&
              svc_of(hdr_r[i], 1'b1) != SVC_NONE) begin
            svc_sel_nxt[i] = 1'b1;
            st_nxt[i] = ST_REQ;
            if (dyn_r[i]) begin
              eu_owned_nxt[eu_r[i]] = 1'b0;
              ersr_nxt[eu_r[i]] = 1'b1;
            end
          end else begin
            if (dyn_r[i]) begin
              eu_owned_nxt[eu_r[i]] = 1'b0;
              ersr_nxt[eu_r[i]] = 1'b1;
            end
            if (link_r[i] != NULL_ADDR) begin
              if (!chain_done_mode[i]) begin
                done_nxt[i] = 1'b1;
                irq_nxt[i] = !writeback_mode[i];
              end
              st_nxt[i] = writeback_mode[i] && !chain_done_mode[i] ?
                          ST_NOTE : ST_FETCH;
              idx_nxt[i] = 5'h00;
            end else begin
              done_nxt[i] = 1'b1;
              irq_nxt[i] = !writeback_mode[i];
              st_nxt[i] = writeback_mode[i] ? ST_NOTE : ST_IDLE;
            end
          end
        end
        default: st_nxt[i] = st_nxt[i];
      endcase
    end
    // Unit reservation per unit, round-robin among requesters
    for (int e = 0; e < NEU; e++) begin
      free[e] = !eu_owned_r[e] && !static_en[e];
    end
    for (int e = 0; e < NEU; e++) begin
      req = '0;
      for (int i = 0; i < NCH; i++) begin
        if (st_r[i] == ST_REQ &&
            svc_of(hdr_r[i], svc_sel_r[i]) == eu_service[e*SVC_W +: SVC_W]) begin
          if (static_en[e] && static_ch[2*e +: 2] == 2'(i)) begin
            st_nxt[i] = ST_MODE;
            eu_nxt[i] = 2'(e);
            dyn_nxt[i] = 1'b0;
          end else if (free[e] && st_nxt[i] == ST_REQ) begin
            req[i] = 1'b1;
          end
        end
      end
      granted = 1'b0;
      for (int j = 1; j <= NCH; j++) begin
        k = 2'(rr_r[e] + 2'(j));
        if (!granted && req[k]) begin
          granted = 1'b1;
          st_nxt[k] = ST_MODE;
          eu_nxt[k] = 2'(e);
          dyn_nxt[k] = 1'b1;
          eu_owned_nxt[e] = 1'b1;
          rr_nxt[e] = k;
        end
      end
      if (granted) begin
        free[e] = 1'b0;
      end
    end
    // Illegal access when a foreign static unit matches and no matching unit is free
    for (int i = 0; i < NCH; i++) begin
      if (st_r[i] == ST_REQ && st_nxt[i] == ST_REQ) begin
        sta_hit = 1'b0;
        fit_free = 1'b0;
        for (int e = 0; e < NEU; e++) begin
          if (svc_of(hdr_r[i], svc_sel_r[i]) ==
              eu_service[e*SVC_W +: SVC_W]) begin
            sta_hit = sta_hit || static_en[e];
            fit_free = fit_free || free[e];
          end
        end
        if (sta_hit && !fit_free) begin
          ill_nxt[i] = 1'b1;
          irq_nxt[i] = irq_nxt[i] || !ill_r[i];
        end
      end else if (st_r[i] == ST_IDLE && link_wr[i]) begin
        ill_nxt[i] = 1'b0;
      end
    end
    // Bus issue, priority from programmed order then rotation
    if (!bus_valid_r) begin
      granted = 1'b0;
      bus_rr_nxt = bus_rr_r + CH_ONE;
      for (int j = 0; j < NCH; j++) begin
        k = prio_cfg[2*j +: 2] ^ bus_rr_r;
        if (!granted && wants_bus(st_r[k]) && st_nxt[k] == st_r[k]) begin
          granted = 1'b1;
          bus_own_nxt = k;
          bus_valid_nxt = 1'b1;
          bus_req_nxt.write = 1'b0;
          bus_wdata_nxt = NULL_ADDR;
          case (st_r[k])
            ST_FETCH: bus_req_nxt.addr = link_r[k] + AW'({idx_r[k], 2'b00});
            ST_XFER: begin
              bus_req_nxt.addr = ptr_r[k][idx_r[k][2:0]];
              if (skip_r[k][idx_r[k][2:0]]) begin
                bus_valid_nxt = 1'b0;
                idx_nxt[k] = idx_r[k] + 5'h01;
                if (idx_r[k] == 5'(NPAIR - 1)) begin
                  st_nxt[k] = ST_WAIT;
                end
              end
            end
            ST_UNLOAD: begin
              bus_req_nxt.write = 1'b1;
              bus_req_nxt.addr = ptr_r[k][NPAIR-1];
            end
            ST_NOTE: begin
              bus_req_nxt.write = 1'b1;
              bus_req_nxt.addr = base_r[k];
              bus_wdata_nxt = hdr_r[k];
              bus_wdata_nxt[DONE_BIT] = 1'b1;
            end
            default: bus_req_nxt.addr = NULL_ADDR;
          endcase
        end
      end
    end
    for (int i = 0; i < NCH; i++) begin
      busy_nxt[i] = st_nxt[i] != ST_IDLE;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        st_r[i] <= ST_IDLE;
        link_r[i] <= '0;
        hdr_r[i] <= '0;
        idx_r[i] <= '0;
        eu_r[i] <= '0;
        svc_sel_r[i] <= 1'b0;
        dyn_r[i] <= 1'b0;
        unf_r[i] <= '0;
        skip_r[i] <= '0;
        base_r[i] <= '0;
        ptr_r[i] <= '{default: '0};
      end
      for (int e = 0; e < NEU; e++) begin
        rr_r[e] <= '0;
      end
      eu_owned_r <= '0;
      bus_rr_r <= '0;
      ill_r <= '0;
      done_r <= '0;
      irq_r <= '0;
      bus_valid_r <= 1'b0;
      bus_req_r <= '0;
      bus_wdata_r <= '0;
      bus_own_r <= '0;
      mode_r <= '0;
      ersr_r <= '0;
      busy_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        st_r[i] <= st_nxt[i];
        link_r[i] <= link_nxt[i];
        hdr_r[i] <= hdr_nxt[i];
        idx_r[i] <= idx_nxt[i];
        eu_r[i] <= eu_nxt[i];
        svc_sel_r[i] <= svc_sel_nxt[i];
        dyn_r[i] <= dyn_nxt[i];
        unf_r[i] <= unf_nxt[i];
        skip_r[i] <= skip_nxt[i];
        base_r[i] <= base_nxt[i];
        ptr_r[i] <= ptr_nxt[i];
      end
      for (int e = 0; e < NEU; e++) begin
        rr_r[e] <= rr_nxt[e];
      end
      eu_owned_r <= eu_owned_nxt;
      bus_rr_r <= bus_rr_nxt;
      ill_r <= ill_nxt;
      done_r <= done_nxt;
      irq_r <= irq_nxt;
      bus_valid_r <= bus_valid_nxt;
      bus_req_r <= bus_req_nxt;
      bus_wdata_r <= bus_wdata_nxt;
      bus_own_r <= bus_own_nxt;
      mode_r <= mode_nxt;
      ersr_r <= ersr_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus_valid = bus_valid_r;
  assign bus_req = bus_req_r;
  assign bus_wdata = bus_wdata_r;
  assign eu_mode_set = mode_r;
  assign eu_reset = ersr_r;
  assign ch_done = done_r;
  assign ch_irq = irq_r;
  assign illegal_access = ill_r;
  assign ch_busy = busy_r;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      last_unfilled[i*AW +: AW] = unf_r[i];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_bus_hold: assert property (@(posedge clk) disable iff (!rstn)
    bus_valid_r && !bus_ack |=> bus_valid_r && $stable(bus_req_r))
    else $error("bus request dropped");
  a_eu_unique: assert property (@(posedge clk) disable iff (!rstn)
    st_r[0] == ST_WAIT && st_r[1] == ST_WAIT && dyn_r[0] && dyn_r[1]
    |-> eu_r[0] != eu_r[1])
    else $error("unit granted twice");
  a_start_fetch: assert property (@(posedge clk) disable iff (!rstn)
    st_r[0] == ST_IDLE && link_wr[0] && link_data != NULL_ADDR
    |=> st_r[0] == ST_FETCH)
    else $error("pointer write did not start");
  a_mode_then: assert property (@(posedge clk) disable iff (!rstn)
    st_r[0] == ST_MODE |=> mode_r[eu_r[0]] && st_r[0] == ST_XFER)
    else $error("mode not set");
  a_wait_done: assert property (@(posedge clk) disable iff (!rstn)
    st_r[0] == ST_WAIT && eu_done[eu_r[0]] |=> st_r[0] == ST_UNLOAD)
    else $error("done ignored");
  a_dyn_release: assert property (@(posedge clk) disable iff (!rstn)
    st_r[0] == ST_RESET && dyn_r[0] |=> eu_reset[$past(eu_r[0])])
    else $error("dynamic unit not reset");
  a_note_done: assert property (@(posedge clk) disable iff (!rstn)
    bus_valid_r && bus_req_r.write && st_r[bus_own_r] == ST_NOTE
    |-> bus_wdata_r[DONE_BIT])
    else $error("writeback lacks done");
  a_ill_irq: assert property (@(posedge clk) disable iff (!rstn)
    $rose(ill_r[0]) |-> irq_r[0])
    else $error("illegal access without interrupt");
  c_fetch: cover property (@(posedge clk) st_r[0] == ST_FETCH);
  c_wait: cover property (@(posedge clk) st_r[1] == ST_WAIT);
  c_ill: cover property (@(posedge clk) ill_r[2]);
endmodule : crypto_channel_eu_scheduler

// *** core/sched_pkg.sv ***
// What this block does
// - Static reservation keeps unit context
// - Pointer write starts a channel
// - Dynamic mode reserves unit before data
// - No free unit means channel stalls
// - Same-cycle requests granted round-robin
// - Load, run, unload, then release unit
// - Match on another channel's static unit with no free matching unit flags illegal access
// - Four channels with pointer and status
// - Header decoded into first service
// - Programmable channel service priority
// - Set mode, load context, load data
// - Wait done, unload to descriptor addresses
// - Repeat sequence once for the second service
// - Dynamic unit auto reset, static on command
// - Done per descriptor or per chain
// - Zero-length pointers are skipped on load
// - Nonzero next link fetches next descriptor
// - Writeback header with done flag set
package sched_pkg;
  localparam int NCH = 4;
  localparam int NEU = 4;
  localparam int AW = 32;
  localparam int NPAIR = 7;
  localparam int SVC_W = 4;
  localparam logic [1:0] CH_ONE = 2'h1;
  localparam logic [AW-1:0] NULL_ADDR = 32'h0000_0000;
  localparam int DONE_BIT = 0;
  localparam int SVC0_LSB = 4;
  localparam int SVC1_LSB = 8;
  localparam logic [SVC_W-1:0] SVC_NONE = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_FETCH = 4'b0001,
    ST_REQ = 4'b0010,
    ST_MODE = 4'b0011,
    ST_XFER = 4'b0100,
    ST_WAIT = 4'b0101,
    ST_UNLOAD = 4'b0110,
    ST_RESET = 4'b0111,
    ST_NOTE = 4'b1000
  } ch_state_e;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic write;
  } bus_req_s;
endpackage : sched_pkg

// *** tb/host_mem_model.sv ***
`timescale 1ns/10ps
module host_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Descriptor bus
  input wire logic bus_valid,
  input wire sched_pkg::bus_req_s bus_req,
  input wire logic [sched_pkg::AW-1:0] bus_wdata,
  output logic bus_ack,
  output logic [sched_pkg::AW-1:0] bus_rdata,
  // Execution units
  input wire logic [sched_pkg::NEU-1:0] eu_mode_set,
  input wire logic [sched_pkg::NEU-1:0] eu_reset,
  output logic [sched_pkg::NEU-1:0] eu_done
);
  import sched_pkg::*;
  logic [AW-1:0] mem [logic [AW-1:0]];
  logic [AW-1:0] rd_log [$];
  int wait_cnt;
  int acks;
  logic [3:0] run_cnt [NEU];
  // ----------------------------------------
  // Memory, answers fast or slow
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_ack <= 1'b0;
      bus_rdata <= 32'h0000_0000;
      wait_cnt <= 0;
      acks <= 0;
    end else if (bus_ack) begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
    end else if (bus_valid) begin
      if (wait_cnt >= acks % 3) begin
        bus_ack <= 1'b1;
        wait_cnt <= 0;
        acks <= acks + 1;
        if (bus_req.write) begin
          mem[bus_req.addr] = bus_wdata;
        end else begin
          rd_log.push_back(bus_req.addr);
          bus_rdata <= mem.exists(bus_req.addr) ? mem[bus_req.addr]
                                                : ~bus_rdata;
        end
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end else begin
      bus_rdata <= ~bus_rdata;
    end
  end
  // ----------------------------------------
  // Units finish some cycles after mode set
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eu_done <= '0;
      for (int i = 0; i < NEU; i++) run_cnt[i] <= 4'h0;
    end else begin
      for (int i = 0; i < NEU; i++) begin
        if (eu_mode_set[i]) begin
          eu_done[i] <= 1'b0;
          run_cnt[i] <= 4'h6;
        end else if (eu_reset[i]) begin
          eu_done[i] <= 1'b0;
          run_cnt[i] <= 4'h0;
        end else if (run_cnt[i] == 4'h1) begin
          eu_done[i] <= 1'b1;
          run_cnt[i] <= 4'h0;
        end else if (run_cnt[i] != 4'h0) begin
          run_cnt[i] <= run_cnt[i] - 4'h1;
        end
      end
    end
  end
endmodule : host_mem_model

// *** tb/crypto_channel_eu_scheduler_test.sv ***
`timescale 1ns/10ps
module crypto_channel_eu_scheduler_test;
  import sched_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [NCH-1:0] link_wr = '0;
  logic [AW-1:0] link_data = '0;
  logic [NCH-1:0] chain_done_mode = '0;
  logic [NCH-1:0] writeback_mode = '0;
  logic [2*NCH-1:0] prio_cfg = 8'h1B;
  logic [NEU-1:0] static_en = 4'hC;
  logic [2*NEU-1:0] static_ch = 8'hB0;
  logic [NEU-1:0] static_reset_cmd = '0;
  logic [NEU*SVC_W-1:0] eu_service = 16'h4321;
  logic bus_ack, bus_valid;
  logic [AW-1:0] bus_rdata, bus_wdata;
  bus_req_s bus_req;
  logic [NEU-1:0] eu_done, eu_mode_set, eu_reset;
  logic [NCH-1:0] ch_busy, ch_done, ch_irq, illegal_access;
  logic [NCH*AW-1:0] last_unfilled;
  int done_cnt [NCH] = '{default: 0};
  int irq_cnt [NCH] = '{default: 0};
  int mode_cnt [NEU] = '{default: 0};
  int rst_cnt [NEU] = '{default: 0};
  int d0 [NCH], i0 [NCH], m0 [NEU], r0 [NEU];
  int overlap = 0;
  logic held0 = 1'b0;
  int miscompares = 0;
  int cmp_count = 0;

  always #25 clk = ~clk;

  crypto_channel_eu_scheduler dut_u (.clk(clk), .rstn(rstn),
    .link_wr(link_wr), .link_data(link_data),
    .chain_done_mode(chain_done_mode), .writeback_mode(writeback_mode),
    .prio_cfg(prio_cfg), .static_en(static_en), .static_ch(static_ch),
    .static_reset_cmd(static_reset_cmd), .eu_service(eu_service),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_valid(bus_valid),
    .bus_req(bus_req), .bus_wdata(bus_wdata), .eu_done(eu_done),
    .eu_mode_set(eu_mode_set), .eu_reset(eu_reset), .ch_busy(ch_busy),
    .ch_done(ch_done), .ch_irq(ch_irq), .illegal_access(illegal_access),
    .last_unfilled(last_unfilled));

  host_mem_model mem_u (.clk(clk), .rstn(rstn), .bus_valid(bus_valid),
    .bus_req(bus_req), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .eu_mode_set(eu_mode_set),
    .eu_reset(eu_reset), .eu_done(eu_done));

  // ----------------------------------------
  // Event counters and unit ownership
  // ----------------------------------------
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      done_cnt[i] += int'(ch_done[i] === 1'b1);
      irq_cnt[i] += int'(ch_irq[i] === 1'b1);
      mode_cnt[i] += int'(eu_mode_set[i] === 1'b1);
      rst_cnt[i] += int'(eu_reset[i] === 1'b1);
    end
    if (eu_mode_set[0] === 1'b1) begin
      overlap += int'(held0);
      held0 = 1'b1;
    end else if (eu_reset[0] === 1'b1) begin
      held0 = 1'b0;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string n, input logic [AW-1:0] e,
                       input logic [AW-1:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : check

  function automatic logic [AW-1:0] exp_hdr(input logic [AW-1:0] h,
                                            input bit wb);
    return wb ? (h | 32'h0000_0001) : h;
  endfunction : exp_hdr

  function automatic logic [AW-1:0] was_read(input logic [AW-1:0] a);
    foreach (mem_u.rd_log[i]) if (mem_u.rd_log[i] === a) return 32'h1;
    return 32'h0;
  endfunction : was_read

  // Every descriptor carries its whole context; pair one has zero length
  task automatic put_desc(input logic [AW-1:0] a, input logic [AW-1:0] h,
                          input logic [AW-1:0] nx);
    mem_u.mem[a] = h;
    for (int k = 0; k < NPAIR; k++) begin
      mem_u.mem[a + 32'(4 + 8*k)] = (k == 1) ? 32'h0000_0000
                                    : 32'($urandom_range(60, 4));
      mem_u.mem[a + 32'(8 + 8*k)] = a + 32'h0010_0000 + 32'(64*k);
    end
    mem_u.mem[a + 32'h0000_003C] = nx;
  endtask : put_desc

  task automatic snap();
    d0 = done_cnt;
    i0 = irq_cnt;
    m0 = mode_cnt;
    r0 = rst_cnt;
  endtask : snap

  task automatic start(input logic [NCH-1:0] m, input logic [AW-1:0] a);
    link_data <= a;
    link_wr <= m;
    @(posedge clk);
    link_wr <= '0;
  endtask : start

  task automatic wait_idle(input int c);
    int n;
    n = 0;
    @(posedge clk);
    while (ch_busy[c] !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    check("ch_busy", 32'h0, 32'(ch_busy[c]));
    repeat (3) @(posedge clk);
  endtask : wait_idle

  task automatic results();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // Scenarios; units touched through channels, except one static_reset_cmd pulse
  // ----------------------------------------
  initial begin
    logic [AW-1:0] a, b, h;
    int s0, s1;
    void'($urandom(45563));
    repeat (4) @(posedge clk);
    check("reset outs", 32'h0, {bus_valid, eu_mode_set, eu_reset, ch_busy,
          ch_done, ch_irq, illegal_access, last_unfilled[2:0]});
    rstn <= 1'b1;
    prio_cfg <= 8'($urandom);
    for (int c = 0; c < NCH; c++) begin
      s0 = (c == 3) ? 3 : (c % 2) + 1;
      s1 = (c == 0) ? 2 : 0;
      a = {16'h0001, 4'(c), 12'($urandom) & 12'hFC0};
      h = {20'($urandom), 4'(s1), 4'(s0), 4'h0};
      put_desc(a, h, 32'h0000_0000);
      snap();
      @(posedge clk);
      writeback_mode[c] <= c[0];
      start(4'(1 << c), a);
      wait_idle(c);
      check("header", exp_hdr(h, c[0]), mem_u.mem[a]);
      check("done", 32'(d0[c] + 1), 32'(done_cnt[c]));
      check("irq", 32'(i0[c] + int'(!c[0])), 32'(irq_cnt[c]));
      check("skip", 32'h0, was_read(a + 32'h0010_0040));
      check("loaded", 32'h1, was_read(a + 32'h0010_0000));
      check("mode", 32'(m0[s0-1] + 1), 32'(mode_cnt[s0-1]));
      check("mode2", 32'(m0[1] + int'(s0 == 2 || s1 == 2)),
            32'(mode_cnt[1]));
      check("eu_reset", 32'(r0[s0-1] + int'(c != 3)),
            32'(rst_cnt[s0-1]));
    end
    // Two channels contend for one unit
    a = 32'h0002_0000;
    put_desc(a, 32'h0000_0010, 32'h0000_0000);
    put_desc(32'h0003_0000, 32'h0000_0010, 32'h0000_0000);
    snap();
    @(posedge clk);
    writeback_mode <= 4'hF;
    start(4'h3, a);
    repeat (3) @(posedge clk);
    start(4'h2, 32'h0003_0000);
    wait_idle(0);
    wait_idle(1);
    check("refused", 32'h0, was_read(32'h0003_0000));
    check("both", 32'(m0[0] + 2), 32'(mode_cnt[0]));
    check("released", 32'(r0[0] + 2), 32'(rst_cnt[0]));
    check("overlap", 32'h0, 32'(overlap));
    start(4'h4, 32'h0000_0000);
    @(posedge clk);
    check("zero link", 32'h0, 32'(ch_busy[2]));
    // Chain with notice at the end only
    a = 32'h0004_0000;
    b = 32'h0004_0800;
    h = {20'($urandom), 8'h02, 4'h0};
    put_desc(a, h, b);
    put_desc(b, h, 32'h0000_0000);
    snap();
    @(posedge clk);
    chain_done_mode <= 4'h4;
    start(4'h4, a);
    wait_idle(2);
    check("next read", 32'h1, was_read(b));
    check("chain done", 32'(d0[2] + 1), 32'(done_cnt[2]));
    check("first hdr", h, mem_u.mem[a]);
    check("last hdr", exp_hdr(h, 1'b1), mem_u.mem[b]);
    // Static unit reset on command
    @(posedge clk);
    static_reset_cmd <= 4'h4;
    @(posedge clk);
    static_reset_cmd <= 4'h0;
    @(posedge clk);
    check("static reset", 32'h1, 32'(eu_reset[2]));
    // Service held only by another channel's static unit
    a = 32'h0005_0000;
    put_desc(a, 32'h0000_0040, 32'h0000_0000);
    snap();
    @(posedge clk);
    start(4'h1, a);
    for (int n = 0; n < 300 && illegal_access[0] !== 1'b1; n++) begin
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    check("illegal", 32'h1, 32'(illegal_access[0]));
    check("illegal irq", 32'(i0[0] + 1), 32'(irq_cnt[0]));
    check("unfilled", 32'h1,
          32'(last_unfilled[AW-1:0] - a < 32'h0000_0040));
    results();
  end

  initial begin
    #(50 * 60000);
    miscompares++;
    results();
  end
endmodule : crypto_channel_eu_scheduler_test
